// ===== design/gpdr_map.svh
// register indices, field positions, reset values and timing counts of the port data block
// assumes a 3-bit word index on the register port and a 16-bit data path
//
// Behaviour
// - a write to a general-output pin's data bit drives that value at once
// - reading a general-output pin returns the stored bit, not the pin level
// - reading a general-input pin returns the sampled pin level
// - writing a general-input pin updates storage only; the pin stays released
// - pins owned by a peripheral read storage; writes never touch the pin
// - 8-pin port sits in bits 7..0 of one 16-bit register, upper byte reserved
// - 25-pin port: pins 24..16 in upper bits 8..0, pins 15..0 in lower 15..0
// - 21-pin port: upper bits 4..0 and lower bits 15..0 behave identically
// - reserved bits always read zero; software writes zero there
// - on watchdog reset, peripheral-output pins drive their data bit one clock
// - an external reset gives no one-cycle drive; only the watchdog reset does
`ifndef GPDR_MAP_SVH
`define GPDR_MAP_SVH

`define GPDR_IDX_C_UPPER   3'h0
`define GPDR_IDX_C_LOWER   3'h1
`define GPDR_IDX_D_WORD    3'h2
`define GPDR_IDX_E_UPPER   3'h3
`define GPDR_IDX_E_LOWER   3'h4

`define GPDR_C_PINS        21
`define GPDR_D_PINS        8
`define GPDR_E_PINS        25
`define GPDR_C_UPPER_BITS  5
`define GPDR_E_UPPER_BITS  9
`define GPDR_LOWER_BITS    16

`define GPDR_DATA_RST      16'h0000
`define GPDR_WORD_ZERO     16'h0000

`define GPDR_WDOG_DRIVE_CYCLES 1

`endif

// ===== design/gpdr_pkg.sv
// types shared by the port data block
// assumes gpdr_map.svh supplies the widths
`include "gpdr_map.svh"
`default_nettype none

package gpdr_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } gpdr_bus_req_t;

    typedef enum logic [2:0] {
        GPDR_ST_RESET      = 3'b001,
        GPDR_ST_WDOG_DRIVE = 3'b010,
        GPDR_ST_RUN        = 3'b100
    } gpdr_state_t;

endpackage

`default_nettype wire

// ===== design/gpdr_port_pins.sv
// per-port pin drive, pin synchroniser and read-value select
// assumes direction and function selects come from logic on the same clock
`default_nettype none

module gpdr_port_pins #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] func,
    input  wire logic [W-1:0] periph_o,
    input  wire logic [W-1:0] periph_oe_n,
    input  wire logic [W-1:0] data,
    input  wire logic [W-1:0] data_next,
    input  wire logic         wdog_drive,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o,
    output logic      [W-1:0] pin_oe_n,
    output logic      [W-1:0] rd_val
);

    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;
    logic [W-1:0] pin_o_reg;
    logic [W-1:0] pin_oe_n_reg;
    logic [W-1:0] pin_o_next;
    logic [W-1:0] pin_oe_n_next;

    always_ff @(posedge clk)
    begin
        sync1_reg    <= pin_i;
        sync2_reg    <= sync1_reg;
        pin_o_reg    <= pin_o_next;
        pin_oe_n_reg <= pin_oe_n_next;
    end

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                if (wdog_drive && func[i] && !periph_oe_n[i])
                begin
                    // old data bit, taken before reset clears storage
                    pin_o_next[i]    = data[i];
                    pin_oe_n_next[i] = 1'b0;
                end
                else if (!rst_n)
                begin
                    pin_o_next[i]    = 1'b0;
                    pin_oe_n_next[i] = 1'b1;
                end
                else if (func[i])
                begin
                    pin_o_next[i]    = periph_o[i];
                    pin_oe_n_next[i] = periph_oe_n[i];
                end
                else if (dir[i])
                begin
                    // next value, so the pin changes on the write edge itself
                    pin_o_next[i]    = data_next[i];
                    pin_oe_n_next[i] = 1'b0;
                end
                else
                begin
                    pin_o_next[i]    = 1'b0;
                    pin_oe_n_next[i] = 1'b1;
                end
            end

            always_comb
            begin
                rd_val[i] = (dir[i] || func[i]) ? data[i] : sync2_reg[i];
            end
        end
    endgenerate

    assign pin_o    = pin_o_reg;
    assign pin_oe_n = pin_oe_n_reg;

endmodule

`default_nettype wire

// ===== design/gpdr_top.sv
// data registers of three general-purpose ports with their pin logic
// assumes one 100 MHz clock, a synchronous reset and a watchdog cause flag
// held valid while rst_n is low; selects come from the pin-function block
`include "gpdr_map.svh"
`default_nettype none

module gpdr_top (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic                               wdog_reset_cause,
    input  wire gpdr_pkg::gpdr_bus_req_t            bus_req,
    output logic      [15:0]                        rdata,
    input  wire logic [`GPDR_C_PINS-1:0]            c_dir,
    input  wire logic [`GPDR_C_PINS-1:0]            c_func,
    input  wire logic [`GPDR_C_PINS-1:0]            c_periph_o,
    input  wire logic [`GPDR_C_PINS-1:0]            c_periph_oe_n,
    input  wire logic [`GPDR_C_PINS-1:0]            c_pin_i,
    output logic      [`GPDR_C_PINS-1:0]            c_pin_o,
    output logic      [`GPDR_C_PINS-1:0]            c_pin_oe_n,
    input  wire logic [`GPDR_D_PINS-1:0]            d_dir,
    input  wire logic [`GPDR_D_PINS-1:0]            d_func,
    input  wire logic [`GPDR_D_PINS-1:0]            d_periph_o,
    input  wire logic [`GPDR_D_PINS-1:0]            d_periph_oe_n,
    input  wire logic [`GPDR_D_PINS-1:0]            d_pin_i,
    output logic      [`GPDR_D_PINS-1:0]            d_pin_o,
    output logic      [`GPDR_D_PINS-1:0]            d_pin_oe_n,
    input  wire logic [`GPDR_E_PINS-1:0]            e_dir,
    input  wire logic [`GPDR_E_PINS-1:0]            e_func,
    input  wire logic [`GPDR_E_PINS-1:0]            e_periph_o,
    input  wire logic [`GPDR_E_PINS-1:0]            e_periph_oe_n,
    input  wire logic [`GPDR_E_PINS-1:0]            e_pin_i,
    output logic      [`GPDR_E_PINS-1:0]            e_pin_o,
    output logic      [`GPDR_E_PINS-1:0]            e_pin_oe_n
);

    logic [`GPDR_C_PINS-1:0]  c_data_reg;
    logic [`GPDR_C_PINS-1:0]  c_data_next;
    logic [`GPDR_D_PINS-1:0]  d_data_reg;
    logic [`GPDR_D_PINS-1:0]  d_data_next;
    logic [`GPDR_E_PINS-1:0]  e_data_reg;
    logic [`GPDR_E_PINS-1:0]  e_data_next;
    logic [15:0]              rdata_reg;
    logic [15:0]              rdata_next;
    logic [15:0]              rd_mux;
    logic [`GPDR_C_PINS-1:0]  c_rd_val;
    logic [`GPDR_D_PINS-1:0]  d_rd_val;
    logic [`GPDR_E_PINS-1:0]  e_rd_val;
    gpdr_pkg::gpdr_state_t    state_reg;
    gpdr_pkg::gpdr_state_t    state_next;
    logic                     wdog_drive;

    // reset tracker: the first reset edge of a watchdog reset opens the drive window
    always_comb
    begin
        case (state_reg)
            gpdr_pkg::GPDR_ST_RUN:
            begin
                if (!rst_n)
                    state_next = wdog_reset_cause ? gpdr_pkg::GPDR_ST_WDOG_DRIVE
                                                  : gpdr_pkg::GPDR_ST_RESET;
                else
                    state_next = gpdr_pkg::GPDR_ST_RUN;
            end
            gpdr_pkg::GPDR_ST_WDOG_DRIVE:
            begin
                state_next = rst_n ? gpdr_pkg::GPDR_ST_RUN : gpdr_pkg::GPDR_ST_RESET;
            end
            gpdr_pkg::GPDR_ST_RESET:
            begin
                state_next = rst_n ? gpdr_pkg::GPDR_ST_RUN : gpdr_pkg::GPDR_ST_RESET;
            end
            default:
            begin
                state_next = gpdr_pkg::GPDR_ST_RESET;
            end
        endcase
    end

    // the drive lasts exactly one clock: only the run-to-drive transition raises it
    assign wdog_drive = (state_reg == gpdr_pkg::GPDR_ST_RUN) && !rst_n
                        && wdog_reset_cause;

    always_ff @(posedge clk)
    begin
        state_reg <= state_next;
    end

    // storage: writes land whatever the pin role, reserved bits are dropped
    always_comb
    begin
        c_data_next = c_data_reg;
        d_data_next = d_data_reg;
        e_data_next = e_data_reg;
        if (!rst_n)
        begin
            c_data_next = `GPDR_C_PINS'(`GPDR_DATA_RST);
            d_data_next = `GPDR_D_PINS'(`GPDR_DATA_RST);
            e_data_next = `GPDR_E_PINS'(`GPDR_DATA_RST);
        end
        else if (bus_req.wr)
        begin
            case (bus_req.addr)
                `GPDR_IDX_C_UPPER:
                    c_data_next[`GPDR_C_PINS-1:`GPDR_LOWER_BITS] =
                        bus_req.wdata[`GPDR_C_UPPER_BITS-1:0];
                `GPDR_IDX_C_LOWER:
                    c_data_next[`GPDR_LOWER_BITS-1:0] = bus_req.wdata;
                `GPDR_IDX_D_WORD:
                    d_data_next = bus_req.wdata[`GPDR_D_PINS-1:0];
                `GPDR_IDX_E_UPPER:
                    e_data_next[`GPDR_E_PINS-1:`GPDR_LOWER_BITS] =
                        bus_req.wdata[`GPDR_E_UPPER_BITS-1:0];
                `GPDR_IDX_E_LOWER:
                    e_data_next[`GPDR_LOWER_BITS-1:0] = bus_req.wdata;
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        c_data_reg <= c_data_next;
        d_data_reg <= d_data_next;
        e_data_reg <= e_data_next;
    end

    // read path: each bit picks pin or storage in the pin block
    always_comb
    begin
        case (bus_req.addr)
            `GPDR_IDX_C_UPPER:
                rd_mux = {11'h000, c_rd_val[`GPDR_C_PINS-1:`GPDR_LOWER_BITS]};
            `GPDR_IDX_C_LOWER:
                rd_mux = c_rd_val[`GPDR_LOWER_BITS-1:0];
            `GPDR_IDX_D_WORD:
                rd_mux = {8'h00, d_rd_val};
            `GPDR_IDX_E_UPPER:
                rd_mux = {7'h00, e_rd_val[`GPDR_E_PINS-1:`GPDR_LOWER_BITS]};
            `GPDR_IDX_E_LOWER:
                rd_mux = e_rd_val[`GPDR_LOWER_BITS-1:0];
            default:
                rd_mux = `GPDR_WORD_ZERO;
        endcase
        if (!rst_n || !bus_req.rd)
            rdata_next = `GPDR_WORD_ZERO;
        else
            rdata_next = rd_mux;
    end

    always_ff @(posedge clk)
    begin
        rdata_reg <= rdata_next;
    end

    assign rdata = rdata_reg;

    gpdr_port_pins #(
        .W (`GPDR_C_PINS)
    ) u_port_c (
        .clk         (clk),
        .rst_n       (rst_n),
        .dir         (c_dir),
        .func        (c_func),
        .periph_o    (c_periph_o),
        .periph_oe_n (c_periph_oe_n),
        .data        (c_data_reg),
        .data_next   (c_data_next),
        .wdog_drive  (wdog_drive),
        .pin_i       (c_pin_i),
        .pin_o       (c_pin_o),
        .pin_oe_n    (c_pin_oe_n),
        .rd_val      (c_rd_val)
    );

    gpdr_port_pins #(
        .W (`GPDR_D_PINS)
    ) u_port_d (
        .clk         (clk),
        .rst_n       (rst_n),
        .dir         (d_dir),
        .func        (d_func),
        .periph_o    (d_periph_o),
        .periph_oe_n (d_periph_oe_n),
        .data        (d_data_reg),
        .data_next   (d_data_next),
        .wdog_drive  (wdog_drive),
        .pin_i       (d_pin_i),
        .pin_o       (d_pin_o),
        .pin_oe_n    (d_pin_oe_n),
        .rd_val      (d_rd_val)
    );

    gpdr_port_pins #(
        .W (`GPDR_E_PINS)
    ) u_port_e (
        .clk         (clk),
        .rst_n       (rst_n),
        .dir         (e_dir),
        .func        (e_func),
        .periph_o    (e_periph_o),
        .periph_oe_n (e_periph_oe_n),
        .data        (e_data_reg),
        .data_next   (e_data_next),
        .wdog_drive  (wdog_drive),
        .pin_i       (e_pin_i),
        .pin_o       (e_pin_o),
        .pin_oe_n    (e_pin_oe_n),
        .rd_val      (e_rd_val)
    );

    property p_out_write_drives;
        @(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `GPDR_IDX_D_WORD && d_dir[0] && !d_func[0]
        |=> !d_pin_oe_n[0] && d_pin_o[0] == $past(bus_req.wdata[0]);
    endproperty
    a_out_write_drives: assert property (p_out_write_drives)
        else $error("output pin did not follow written data");

    property p_out_read_data;
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `GPDR_IDX_D_WORD && d_dir[3] && !d_func[3]
        |=> rdata[3] == $past(d_data_reg[3]);
    endproperty
    a_out_read_data: assert property (p_out_read_data)
        else $error("output pin read did not return stored bit");

    property p_in_read_pin;
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `GPDR_IDX_E_LOWER && !e_dir[5] && !e_func[5]
        |=> rdata[5] == $past(e_pin_i[5], 3);
    endproperty
    a_in_read_pin: assert property (p_in_read_pin)
        else $error("input pin read did not return sampled level");

    property p_in_released;
        @(posedge clk) disable iff (!rst_n)
        !c_dir[9] && !c_func[9] |=> c_pin_oe_n[9];
    endproperty
    a_in_released: assert property (p_in_released)
        else $error("input pin was driven");

    property p_func_follows;
        @(posedge clk) disable iff (!rst_n)
        rst_n && d_func[7] |=> d_pin_o[7] == $past(d_periph_o[7])
                               && d_pin_oe_n[7] == $past(d_periph_oe_n[7]);
    endproperty
    a_func_follows: assert property (p_func_follows)
        else $error("peripheral pin not under peripheral control");

    property p_d_reserved;
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `GPDR_IDX_D_WORD |=> rdata[15:8] == 8'h00;
    endproperty
    a_d_reserved: assert property (p_d_reserved)
        else $error("reserved byte of 8-pin port not zero");

    property p_e_upper_map;
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `GPDR_IDX_E_UPPER && e_dir[24] && !e_func[24]
        |=> rdata[8] == $past(e_data_reg[24]) && rdata[15:9] == 7'h00;
    endproperty
    a_e_upper_map: assert property (p_e_upper_map)
        else $error("upper 25-pin register mapping wrong");

    property p_c_upper_write;
        @(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == `GPDR_IDX_C_UPPER
        |=> c_data_reg[20:16] == $past(bus_req.wdata[4:0])
            && c_data_reg[15:0] == $past(c_data_reg[15:0]);
    endproperty
    a_c_upper_write: assert property (p_c_upper_write)
        else $error("upper 21-pin register write wrong");

    property p_c_upper_reserved;
        @(posedge clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `GPDR_IDX_C_UPPER |=> rdata[15:5] == 11'h000;
    endproperty
    a_c_upper_reserved: assert property (p_c_upper_reserved)
        else $error("reserved bits of 21-pin upper register not zero");

    property p_wdog_drive;
        @(posedge clk) disable iff (1'b0)
        state_reg == gpdr_pkg::GPDR_ST_RUN && !rst_n && wdog_reset_cause
        && d_func[2] && !d_periph_oe_n[2]
        |=> !d_pin_oe_n[2] && d_pin_o[2] == $past(d_data_reg[2])
            && state_reg == gpdr_pkg::GPDR_ST_WDOG_DRIVE
            ##1 state_reg != gpdr_pkg::GPDR_ST_WDOG_DRIVE;
    endproperty
    a_wdog_drive: assert property (p_wdog_drive)
        else $error("watchdog reset drive missing or longer than one clock");

    property p_ext_no_drive;
        @(posedge clk) disable iff (1'b0)
        !rst_n && !wdog_reset_cause
        |=> (&c_pin_oe_n) && (&d_pin_oe_n) && (&e_pin_oe_n);
    endproperty
    a_ext_no_drive: assert property (p_ext_no_drive)
        else $error("pin driven during external reset");

    property p_reset_clears;
        @(posedge clk) disable iff (1'b0)
        !rst_n |=> c_data_reg == 21'h000000 && d_data_reg == 8'h00
                   && e_data_reg == 25'h0000000 && rdata == 16'h0000;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("data not cleared by reset");

endmodule

`default_nettype wire

// ===== test/gpdr_far_pins.sv
// far side of one port: pad wiring plus whatever the board puts on the pins
// assumes one instance per port; the bench chooses which pins it drives from outside
`default_nettype none

module gpdr_far_pins #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] pin_o,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // a floating pad flips every cycle so a stale level can never pass for a read
    logic [W-1:0] float_val;

    initial float_val = '0;

    always @(posedge clk)
    begin
        float_val <= ~float_val;
    end

    always_comb
    begin
        for (int b = 0; b < W; b++)
        begin
            if (!pin_oe_n[b])
                pin_i[b] = pin_o[b];
            else if (ext_en[b])
                pin_i[b] = ext_val[b];
            else
                pin_i[b] = float_val[b];
        end
    end
endmodule

`default_nettype wire

// ===== test/tb.sv
// self-checking bench of the three port data registers and their pins
// assumes the register port answers a read in the next cycle and never stalls
`include "gpdr_map.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CW = `GPDR_C_PINS;
    localparam int DW = `GPDR_D_PINS;
    localparam int EW = `GPDR_E_PINS;

    logic                    clk;
    logic                    rst_n;
    logic                    wdog;
    gpdr_pkg::gpdr_bus_req_t bus_req;
    logic [15:0]             rdata;
    logic [CW-1:0]           c_dir, c_func, c_po, c_poe_n, c_ext, c_ext_en;
    logic [CW-1:0]           c_pin_i, c_pin_o, c_pin_oe_n;
    logic [DW-1:0]           d_dir, d_func, d_po, d_poe_n, d_ext, d_ext_en;
    logic [DW-1:0]           d_pin_i, d_pin_o, d_pin_oe_n;
    logic [EW-1:0]           e_dir, e_func, e_po, e_poe_n, e_ext, e_ext_en;
    logic [EW-1:0]           e_pin_i, e_pin_o, e_pin_oe_n;
    int                      fails;
    int                      total_checks;

    gpdr_top i_gpdr_top (
        .clk(clk), .rst_n(rst_n), .wdog_reset_cause(wdog), .bus_req(bus_req), .rdata(rdata),
        .c_dir(c_dir), .c_func(c_func), .c_periph_o(c_po), .c_periph_oe_n(c_poe_n),
        .c_pin_i(c_pin_i), .c_pin_o(c_pin_o), .c_pin_oe_n(c_pin_oe_n),
        .d_dir(d_dir), .d_func(d_func), .d_periph_o(d_po), .d_periph_oe_n(d_poe_n),
        .d_pin_i(d_pin_i), .d_pin_o(d_pin_o), .d_pin_oe_n(d_pin_oe_n),
        .e_dir(e_dir), .e_func(e_func), .e_periph_o(e_po), .e_periph_oe_n(e_poe_n),
        .e_pin_i(e_pin_i), .e_pin_o(e_pin_o), .e_pin_oe_n(e_pin_oe_n)
    );

    gpdr_far_pins #(.W(CW)) i_gpdr_far_pins_c (.clk(clk), .pin_o(c_pin_o),
        .pin_oe_n(c_pin_oe_n), .ext_val(c_ext), .ext_en(c_ext_en), .pin_i(c_pin_i));
    gpdr_far_pins #(.W(DW)) i_gpdr_far_pins_d (.clk(clk), .pin_o(d_pin_o),
        .pin_oe_n(d_pin_oe_n), .ext_val(d_ext), .ext_en(d_ext_en), .pin_i(d_pin_i));
    gpdr_far_pins #(.W(EW)) i_gpdr_far_pins_e (.clk(clk), .pin_o(e_pin_o),
        .pin_oe_n(e_pin_oe_n), .ext_val(e_ext), .ext_en(e_ext_en), .pin_i(e_pin_i));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: read %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: pins %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    // one idle cycle after each access keeps every strobe to one assignment per step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus_req <= '0;
        #1 chk_reg(rdata, exp);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end

    initial
    begin
        {rst_n, wdog, bus_req} = '0;
        {c_dir, c_func, c_po, c_poe_n, c_ext, c_ext_en} = '0;
        {d_dir, d_func, d_po, d_poe_n, d_ext, d_ext_en} = '0;
        {e_dir, e_func, e_po, e_poe_n, e_ext, e_ext_en} = '0;
        // outputs first, so the reads after reset show storage, not floating pads
        {c_dir, d_dir, e_dir} = '1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(i[2:0], 16'h0000);
        chk_pin(c_pin_oe_n, 32'h00000000);
        chk_pin(e_pin_o, 32'h00000000);
        @(posedge clk);
        d_dir <= 8'hFF;
        wr(3'h2, 16'h00A5);
        #1 chk_pin({d_pin_oe_n, d_pin_o}, 32'h00A5);
        rd(3'h2, 16'h00A5);
        @(posedge clk);
        d_dir <= 8'h00;
        d_ext <= 8'h3C;
        d_ext_en <= 8'hFF;
        wr(3'h2, 16'h005A);
        #1 chk_pin(d_pin_oe_n, 32'h00FF);
        repeat (3) @(posedge clk);
        rd(3'h2, 16'h003C);
        @(posedge clk);
        d_dir <= 8'hFF;
        d_ext_en <= 8'h00;
        @(posedge clk);
        #1 chk_pin(d_pin_o, 32'h005A);
        @(posedge clk);
        d_func <= 8'hFF;
        d_po <= 8'h0F;
        wr(3'h2, 16'h0011);
        #1 chk_pin({d_pin_oe_n, d_pin_o}, 32'h000F);
        rd(3'h2, 16'h0011);
        @(posedge clk);
        c_dir <= '1;
        e_dir <= '1;
        wr(3'h0, 16'h001F);
        wr(3'h1, 16'hA55A);
        #1 chk_pin(c_pin_o, 32'h001FA55A);
        rd(3'h0, 16'h001F);
        rd(3'h1, 16'hA55A);
        wr(3'h3, 16'h01FF);
        wr(3'h4, 16'h1234);
        #1 chk_pin(e_pin_o, 32'h01FF1234);
        rd(3'h3, 16'h01FF);
        rd(3'h4, 16'h1234);
        // unmapped indices keep nothing and read zero
        wr(3'h5, 16'hFFFF);
        rd(3'h5, 16'h0000);
        rd(3'h7, 16'h0000);
        @(posedge clk);
        c_dir <= '0;
        e_dir <= '0;
        c_ext <= 21'h0ABCDE;
        e_ext <= 25'h0F3C96A;
        c_ext_en <= '1;
        e_ext_en <= '1;
        repeat (4) @(posedge clk);
        #1 chk_pin(e_pin_oe_n, 32'h01FFFFFF);
        rd(3'h0, 16'h000A);
        rd(3'h1, 16'hBCDE);
        rd(3'h3, 16'h00F3);
        rd(3'h4, 16'hC96A);
        @(posedge clk);
        d_po <= 8'h00;
        wr(3'h2, 16'h00FF);
        @(posedge clk);
        rst_n <= 1'b0;
        wdog <= 1'b1;
        @(posedge clk);
        #1 chk_pin({d_pin_oe_n, d_pin_o}, 32'h00FF);
        chk_pin(c_pin_oe_n, 32'h001FFFFF);
        @(posedge clk);
        #1 chk_pin(d_pin_oe_n, 32'h00FF);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wdog <= 1'b0;
        rd(3'h2, 16'h0000);
        wr(3'h2, 16'h00FF);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1 chk_pin(d_pin_oe_n, 32'h00FF);
        @(posedge clk);
        #1 chk_pin(d_pin_oe_n, 32'h00FF);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(3'h2, 16'h0000);
        conclude();
    end
endmodule

`default_nettype wire
